/* rtl/arer_regs.sv */
// event, interrupt enable, status and enable registers of the address resolver
// assumes a plain one-cycle register port and an engine that answers key tries
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module arer_regs
    import arer_pkg::*;
(
    input wire logic i_clk, // system clock, 50 MHz
    input wire logic i_rst_n, // synchronous reset, low
    input wire logic [ADDR_W-1:0] i_addr, // register byte address
    input wire logic [DATA_W-1:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [DATA_W-1:0] o_rdata, // read data, cycle after i_rd
    output logic o_irq, // level interrupt
    input wire arer_try_t i_try, // engine answer to a try
    output logic o_try_req, // try pulse to engine
    output logic [KEY_IDX_W-1:0] o_key_idx, // key under test
    output logic [KEY_OFS_W-1:0] o_key_ofs, // key byte offset in table
    output logic o_enabled, // resolver switched on
    output logic o_busy // scan in progress
);
    // ==========================================================
    // declarations
    logic [NUM_EVT-1:0] irq_en;
    logic [ENABLE_W-1:0] enable;
    logic [KEY_CNT_W-1:0] key_count;
    logic [KEY_IDX_W-1:0] last_idx;
    logic [NUM_EVT-1:0] flags;
    logic [NUM_EVT-1:0] ack_bits;
    logic [DATA_W-1:0] next_rdata;
    arer_evt_t events;
    logic wr_set;
    logic wr_clr;
    logic wr_enable;
    logic wr_count;
    logic wr_ack;
    logic wr_end_evt;
    logic wr_match_evt;
    logic wr_nomatch_evt;
    logic start;
    logic abort;
    logic active;

    // ==========================================================
    // write decode
    assign wr_set = i_wr && arer_hit(i_addr, OFS_IRQ_SET);
    assign wr_clr = i_wr && arer_hit(i_addr, OFS_IRQ_CLR);
    assign wr_enable = i_wr && arer_hit(i_addr, OFS_ENABLE);
    assign wr_count = i_wr && arer_hit(i_addr, OFS_KEY_COUNT);
    assign wr_ack = i_wr && arer_hit(i_addr, OFS_IRQ_ACK);
    assign wr_end_evt = i_wr && arer_hit(i_addr, OFS_END_EVT);
    assign wr_match_evt = i_wr && arer_hit(i_addr, OFS_MATCH_EVT);
    assign wr_nomatch_evt = i_wr && arer_hit(i_addr, OFS_NOMATCH_EVT);
    assign ack_bits = wr_ack ? i_wdata[NUM_EVT-1:0] : '0;
    assign active = enable == ENABLE_ON;

    // ==========================================================
    // task strobes: start only when switched on and idle
    assign start = i_wr && arer_hit(i_addr, OFS_TASK_START) && i_wdata[0] && active && !o_busy;
    assign abort = (i_wr && arer_hit(i_addr, OFS_TASK_STOP) && i_wdata[0]) || !active;

    // ==========================================================
    // interrupt enables, set and clear halves of one register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            irq_en <= RST_IRQ_EN;
        else if (wr_set)
            irq_en <= irq_en | i_wdata[NUM_EVT-1:0];
        else if (wr_clr)
            irq_en <= irq_en & ~i_wdata[NUM_EVT-1:0];
    end

    // ==========================================================
    // enable field
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            enable <= RST_ENABLE;
        else if (wr_enable)
            enable <= i_wdata[ENABLE_W-1:0];
    end

    // ==========================================================
    // resolver-on output
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_enabled <= 1'b0;
        else
            o_enabled <= (wr_enable ? i_wdata[ENABLE_W-1:0] : enable) == ENABLE_ON;
    end

    // ==========================================================
    // key count, kept as written; the scanner treats zero as one
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            key_count <= RST_KEY_COUNT;
        else if (wr_count)
            key_count <= i_wdata[KEY_CNT_W-1:0];
    end

    // ==========================================================
    // last matching key index, captured on each match
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            last_idx <= RST_LAST_IDX;
        else if (events.match)
            last_idx <= o_key_idx;
    end

    // ==========================================================
    // key sequencer
    arer_key_scan u_scan
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_start(start),
        .i_abort(abort),
        .i_key_count(key_count),
        .i_try(i_try),
        .o_try_req(o_try_req),
        .o_key_idx(o_key_idx),
        .o_key_ofs(o_key_ofs),
        .o_events(events),
        .o_busy(o_busy)
    );

    // ==========================================================
    // sticky event flags, one per event bit
    arer_event_flag u_end_flag
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(events.done),
        .i_wr(wr_end_evt),
        .i_wbit(i_wdata[0]),
        .i_ack(ack_bits[EVT_END_BIT]),
        .o_flag(flags[EVT_END_BIT])
    );
    arer_event_flag u_match_flag
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(events.match),
        .i_wr(wr_match_evt),
        .i_wbit(i_wdata[0]),
        .i_ack(ack_bits[EVT_MATCH_BIT]),
        .o_flag(flags[EVT_MATCH_BIT])
    );
    arer_event_flag u_nomatch_flag
    (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(events.nomatch),
        .i_wr(wr_nomatch_evt),
        .i_wbit(i_wdata[0]),
        .i_ack(ack_bits[EVT_NOMATCH_BIT]),
        .o_flag(flags[EVT_NOMATCH_BIT])
    );

    // ==========================================================
    // interrupt level, flag and enable both needed
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_irq <= 1'b0;
        else
            o_irq <= |(flags & irq_en);
    end

    // ==========================================================
    // read mux; unmapped and write-only addresses read zero
    always_comb
    begin
        next_rdata = '0;
        if (i_rd)
        begin
            if (arer_hit(i_addr, OFS_END_EVT))
                next_rdata = {{(DATA_W-1){1'b0}}, flags[EVT_END_BIT]};
            else if (arer_hit(i_addr, OFS_MATCH_EVT))
                next_rdata = {{(DATA_W-1){1'b0}}, flags[EVT_MATCH_BIT]};
            else if (arer_hit(i_addr, OFS_NOMATCH_EVT))
                next_rdata = {{(DATA_W-1){1'b0}}, flags[EVT_NOMATCH_BIT]};
            else if (arer_hit(i_addr, OFS_IRQ_SET) || arer_hit(i_addr, OFS_IRQ_CLR))
                next_rdata = {{(DATA_W-NUM_EVT){1'b0}}, irq_en};
            else if (arer_hit(i_addr, OFS_LAST_IDX))
                next_rdata = {{(DATA_W-KEY_IDX_W){1'b0}}, last_idx};
            else if (arer_hit(i_addr, OFS_ENABLE))
                next_rdata = {{(DATA_W-ENABLE_W){1'b0}}, enable};
            else if (arer_hit(i_addr, OFS_KEY_COUNT))
                next_rdata = {{(DATA_W-KEY_CNT_W){1'b0}}, key_count};
            else if (arer_hit(i_addr, OFS_IRQ_STATUS))
                next_rdata = {{(DATA_W-NUM_EVT){1'b0}}, flags};
        end
    end

    // ==========================================================
    // read data register, valid only in the cycle after the strobe
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_rdata <= '0;
        else
            o_rdata <= next_rdata;
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_set_enables;
        wr_set |=> (irq_en & $past(i_wdata[NUM_EVT-1:0])) == $past(i_wdata[NUM_EVT-1:0])
            && (irq_en & $past(irq_en)) == $past(irq_en);
    endproperty
    a_set_enables: assert property (p_set_enables) else $error("enable set write misbehaved");

    property p_clr_disables;
        wr_clr |=> (irq_en & $past(i_wdata[NUM_EVT-1:0])) == 3'h0
            && (irq_en | $past(i_wdata[NUM_EVT-1:0])) == ($past(irq_en) | $past(i_wdata[NUM_EVT-1:0]));
    endproperty
    a_clr_disables: assert property (p_clr_disables) else $error("enable clear write misbehaved");

    property p_enable_readback;
        (i_rd && (arer_hit(i_addr, OFS_IRQ_SET) || arer_hit(i_addr, OFS_IRQ_CLR)))
            |=> o_rdata == {29'h0, $past(irq_en)};
    endproperty
    a_enable_readback: assert property (p_enable_readback) else $error("enable readback wrong");

    property p_irq_level;
        ##1 o_irq == $past(|(flags & irq_en));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not flag and enable");

    property p_index_capture;
        events.match |=> last_idx == $past(o_key_idx);
    endproperty
    a_index_capture: assert property (p_index_capture) else $error("last key index wrong");

    property p_start_needs_on;
        (i_wr && arer_hit(i_addr, OFS_TASK_START) && enable != ENABLE_ON) |=> !o_try_req [*2];
    endproperty
    a_start_needs_on: assert property (p_start_needs_on) else $error("scan ran while disabled");

    property p_enabled_out;
        ##1 o_enabled == (enable == ENABLE_ON);
    endproperty
    a_enabled_out: assert property (p_enabled_out) else $error("enabled output disagrees");

    sequence s_flag_held;
        flags[EVT_MATCH_BIT] && !ack_bits[EVT_MATCH_BIT]
            && !(i_wr && arer_hit(i_addr, OFS_MATCH_EVT) && !i_wdata[0]);
    endsequence
    property p_match_sticky;
        s_flag_held |=> flags[EVT_MATCH_BIT];
    endproperty
    a_match_sticky: assert property (p_match_sticky) else $error("match flag dropped by itself");

    property p_nomatch_sets;
        events.nomatch |=> flags[EVT_NOMATCH_BIT] && flags[EVT_END_BIT];
    endproperty
    a_nomatch_sets: assert property (p_nomatch_sets) else $error("no-match flag not set");

    // readback of the index, enable, no-match, status and key count registers, and writes ignored by the index
    property p_index_readback;
        (i_rd && arer_hit(i_addr, OFS_LAST_IDX)) |=> o_rdata == {28'h0, $past(last_idx)};
    endproperty
    a_index_readback: assert property (p_index_readback) else $error("index readback wrong");

    property p_index_ro;
        (i_wr && arer_hit(i_addr, OFS_LAST_IDX) && !events.match) |=> last_idx == $past(last_idx);
    endproperty
    a_index_ro: assert property (p_index_ro) else $error("index took a write");

    property p_enable_field_read;
        (i_rd && arer_hit(i_addr, OFS_ENABLE)) |=> o_rdata == {30'h0, $past(enable)};
    endproperty
    a_enable_field_read: assert property (p_enable_field_read) else $error("enable readback wrong");

    property p_nomatch_read;
        (i_rd && arer_hit(i_addr, OFS_NOMATCH_EVT)) |=> o_rdata == {31'h0, $past(flags[EVT_NOMATCH_BIT])};
    endproperty
    a_nomatch_read: assert property (p_nomatch_read) else $error("no-match readback wrong");

    property p_status_read;
        (i_rd && arer_hit(i_addr, OFS_IRQ_STATUS)) |=> o_rdata == {29'h0, $past(flags)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status readback wrong");

    property p_count_read;
        (i_rd && arer_hit(i_addr, OFS_KEY_COUNT)) |=> o_rdata == {27'h0, $past(key_count)};
    endproperty
    a_count_read: assert property (p_count_read) else $error("key count readback wrong");

    // flag and scan control
    property p_off_idles;
        !active |=> !o_busy && !o_try_req;
    endproperty
    a_off_idles: assert property (p_off_idles) else $error("scan ran while off");

    property p_match_sets;
        events.match |=> flags[EVT_MATCH_BIT] && flags[EVT_END_BIT];
    endproperty
    a_match_sets: assert property (p_match_sets) else $error("match flag not set");

    property p_clear_by_zero;
        (wr_match_evt && !i_wdata[0] && !events.match) |=> !flags[EVT_MATCH_BIT];
    endproperty
    a_clear_by_zero: assert property (p_clear_by_zero) else $error("match flag kept after zero");

    property p_abort_ends;
        (abort && o_busy) |=> ##1 flags[EVT_END_BIT];
    endproperty
    a_abort_ends: assert property (p_abort_ends) else $error("stop gave no end event");

    property p_ack_clears;
        (wr_ack && i_wdata[EVT_NOMATCH_BIT] && !events.nomatch) |=> !flags[EVT_NOMATCH_BIT];
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack left flag set");

    sequence s_nomatch_held;
        flags[EVT_NOMATCH_BIT] && !ack_bits[EVT_NOMATCH_BIT] && !(wr_nomatch_evt && !i_wdata[0]);
    endsequence
    property p_nomatch_sticky;
        s_nomatch_held |=> flags[EVT_NOMATCH_BIT];
    endproperty
    a_nomatch_sticky: assert property (p_nomatch_sticky) else $error("no-match flag dropped");
endmodule

/* include/arer_pkg.sv */
// constants, field layouts and carrier types of the address resolver event registers
// assumes a 12-bit word-aligned register address and a 32-bit data path
package arer_pkg;
    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // ==========================================================
    // register byte offsets
    localparam logic [11:0] OFS_TASK_START = 12'h000;
    localparam logic [11:0] OFS_TASK_STOP = 12'h008;
    localparam logic [11:0] OFS_END_EVT = 12'h100;
    localparam logic [11:0] OFS_MATCH_EVT = 12'h104;
    localparam logic [11:0] OFS_NOMATCH_EVT = 12'h108;
    localparam logic [11:0] OFS_IRQ_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFS_LAST_IDX = 12'h400;
    localparam logic [11:0] OFS_ENABLE = 12'h500;
    localparam logic [11:0] OFS_KEY_COUNT = 12'h504;
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h600;
    localparam logic [11:0] OFS_IRQ_ACK = 12'h604;
    // ==========================================================
    // event bit positions, shared by enables, status and ack
    localparam int EVT_END_BIT = 0;
    localparam int EVT_MATCH_BIT = 1;
    localparam int EVT_NOMATCH_BIT = 2;
    localparam int NUM_EVT = 3;
    localparam logic [NUM_EVT-1:0] RST_IRQ_EN = 3'h0;
    // ==========================================================
    // enable field, key index and key table geometry
    localparam int ENABLE_W = 2;
    localparam logic [ENABLE_W-1:0] ENABLE_ON = 2'h3;
    localparam logic [ENABLE_W-1:0] RST_ENABLE = 2'h0;
    localparam int KEY_IDX_W = 4;
    localparam logic [KEY_IDX_W-1:0] RST_LAST_IDX = 4'h0;
    localparam int KEY_CNT_W = 5;
    localparam logic [KEY_CNT_W-1:0] RST_KEY_COUNT = 5'h01;
    localparam int KEY_OFS_W = 8;
    localparam logic [3:0] KEY_STRIDE_PAD = 4'h0;
    // ==========================================================
    // carrier types
    typedef struct packed {
        logic done;
        logic hit;
    } arer_try_t;
    typedef struct packed {
        logic nomatch;
        logic match;
        logic done;
    } arer_evt_t;
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'h0,
        SCAN_ISSUE = 2'h1,
        SCAN_WAIT = 2'h3,
        SCAN_FINISH = 2'h2
    } arer_scan_t;
    // address decode used by every register
    function automatic logic arer_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction
endpackage

/* rtl/arer_event_flag.sv */
// one sticky event flag with a software write and a write-one acknowledge
// assumes set, write and ack are one-cycle pulses on i_clk
`timescale 1ns/1ns
module arer_event_flag
    import arer_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // synchronous reset, low
    input wire logic i_set, // event pulse from the scanner
    input wire logic i_wr, // software write to the flag
    input wire logic i_wbit, // value written
    input wire logic i_ack, // write-one acknowledge
    output logic o_flag // flag state
);
    // ==========================================================
    // flag update, a new event beats any clear in the same cycle
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_flag <= 1'b0;
        else if (i_set)
            o_flag <= 1'b1;
        else if (i_ack)
            o_flag <= 1'b0;
        else if (i_wr)
            o_flag <= i_wbit;
    end
endmodule

/* rtl/arer_key_scan.sv */
// key sequencer: walks the key table from key 0 and stops on the first hit
// assumes the engine answers each try with one done pulse, hit beside it
`timescale 1ns/1ns
module arer_key_scan
    import arer_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // synchronous reset, low
    input wire logic i_start, // start pulse
    input wire logic i_abort, // stop or disable
    input wire logic [KEY_CNT_W-1:0] i_key_count, // keys to try
    input wire arer_try_t i_try, // engine answer
    output logic o_try_req, // try pulse to engine
    output logic [KEY_IDX_W-1:0] o_key_idx, // key under test
    output logic [KEY_OFS_W-1:0] o_key_ofs, // byte offset of key
    output arer_evt_t o_events, // event pulses
    output logic o_busy // scan in progress
);
    arer_scan_t state;
    arer_scan_t next_state;
    logic [KEY_IDX_W-1:0] next_idx;
    logic last;
    logic answer;

    // ==========================================================
    // next state and next key index
    assign last = (({1'b0, o_key_idx} + 5'h01) >= i_key_count) || (&o_key_idx); // table ends at key 15
    assign answer = (state == SCAN_WAIT) && i_try.done;
    always_comb
    begin
        next_state = state;
        next_idx = o_key_idx;
        case (state)
            SCAN_IDLE:
            begin
                if (i_start)
                begin
                    next_state = SCAN_ISSUE;
                    next_idx = '0;
                end
            end
            SCAN_ISSUE:
                next_state = SCAN_WAIT;
            SCAN_WAIT:
            begin
                if (answer && (i_try.hit || last))
                    next_state = SCAN_FINISH;
                else if (answer)
                begin
                    next_state = SCAN_ISSUE;
                    next_idx = o_key_idx + 4'h1;
                end
            end
            SCAN_FINISH:
                next_state = SCAN_IDLE;
            default:
                next_state = SCAN_IDLE;
        endcase
        if (i_abort)
            next_state = SCAN_IDLE;
    end

    // ==========================================================
    // state, index and try request
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state <= SCAN_IDLE;
            o_key_idx <= '0;
            o_key_ofs <= '0;
            o_try_req <= 1'b0;
            o_busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            o_key_idx <= next_idx;
            o_key_ofs <= {next_idx, KEY_STRIDE_PAD};
            o_try_req <= next_state == SCAN_ISSUE;
            o_busy <= next_state != SCAN_IDLE;
        end
    end

    // ==========================================================
    // outcome pulses, one cycle each
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_events <= '0;
        else
        begin
            o_events.match <= answer && i_try.hit && !i_abort;
            o_events.nomatch <= answer && !i_try.hit && last && !i_abort;
            o_events.done <= (answer && (i_try.hit || last)) || (i_abort && state != SCAN_IDLE);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_hit_answer;
        answer && i_try.hit && !i_abort;
    endsequence
    property p_hit_stops;
        s_hit_answer |=> o_events.match && o_events.done ##1 !o_try_req [*3];
    endproperty
    a_hit_stops: assert property (p_hit_stops) else $error("scan went on after a hit");
    property p_one_outcome;
        o_events.done |-> !(o_events.match && o_events.nomatch);
    endproperty
    a_one_outcome: assert property (p_one_outcome) else $error("match and no-match together");
    property p_first_key;
        (state == SCAN_IDLE && i_start && !i_abort) |=> o_try_req && o_key_idx == 4'h0 && o_key_ofs == 8'h00;
    endproperty
    a_first_key: assert property (p_first_key) else $error("scan did not start at key 0");
    property p_stride;
        o_try_req |-> o_key_ofs == {o_key_idx, KEY_STRIDE_PAD};
    endproperty
    a_stride: assert property (p_stride) else $error("key offset not index times 16");
endmodule

/* bench/arer_engine_model.sv */
// behavioural resolution engine that answers the key tries of the event register block
// assumes try requests are one-cycle pulses sampled on the rising edge of i_clk
`timescale 1ns/1ns
module arer_engine_model
    import arer_pkg::*;
(
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // synchronous reset, low
    input wire logic i_try_req, // try pulse from the block
    input wire logic [KEY_IDX_W-1:0] i_key_idx, // key under test
    input wire logic [4:0] i_hit_idx, // key that resolves, 16 for none
    input wire logic [3:0] i_lag, // extra cycles before answering
    output arer_try_t o_try // answer to the block
);
    logic waiting;
    logic [3:0] cnt;
    logic [KEY_IDX_W-1:0] idx;
    // ==========================================================
    // one answer per try after the chosen lag; hit wanders while not valid
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            waiting <= 1'b0;
            cnt <= 4'h0;
            idx <= '0;
            o_try <= '0;
        end
        else
        begin
            o_try.done <= 1'b0;
            o_try.hit <= ~o_try.hit; // meaningless outside a done pulse
            if (i_try_req)
            begin
                waiting <= 1'b1;
                cnt <= i_lag;
                idx <= i_key_idx;
            end
            else if (waiting)
            begin
                if (cnt == 4'h0)
                begin
                    waiting <= 1'b0;
                    o_try.done <= 1'b1;
                    o_try.hit <= ({1'b0, idx} == i_hit_idx);
                end
                else
                    cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

/* bench/test_arer_regs.sv */
// self-checking testbench of the address resolver event registers
// assumes the engine model beside the block and a 50 MHz clock
`timescale 1ns/1ns
module test_arer_regs;
    import arer_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic irq, try_req, enabled, busy;
    logic [KEY_IDX_W-1:0] key_idx;
    logic [KEY_OFS_W-1:0] key_ofs;
    arer_try_t try_ans;
    logic [4:0] hit_idx = 5'h10;
    logic [3:0] lag = 4'h0;
    int fails = 0;
    int compares = 0;
    int ntry = 0;
    // ==========================================================
    // block, engine model and clock
    arer_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
        .o_rdata(rdata), .o_irq(irq), .i_try(try_ans), .o_try_req(try_req), .o_key_idx(key_idx),
        .o_key_ofs(key_ofs), .o_enabled(enabled), .o_busy(busy));
    arer_engine_model u_engine (.i_clk(clk), .i_rst_n(rst_n), .i_try_req(try_req), .i_key_idx(key_idx),
        .i_hit_idx(hit_idx), .i_lag(lag), .o_try(try_ans));
    always #10 clk = ~clk;
    // ==========================================================
    // bus tasks and comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, exp); // read data stand only in this cycle
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        #1;
        while (busy !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 400) fails++; // scan never finished
        settle();
    endtask
    task automatic scan(input logic [4:0] cnt, input logic [4:0] hit, input logic [3:0] lg, input int tries);
        wr(12'h504, {27'h0, cnt});
        hit_idx <= hit;
        lag <= lg;
        ntry = 0;
        wr(12'h000, 32'h1);
        wait_idle();
        chk(32'(ntry), 32'(tries)); // keys tried before stopping
    endtask
    task automatic test_done;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================
    // every try must walk up from key 0 with a 16-byte stride
    always @(posedge clk)
    begin
        if (try_req === 1'b1)
        begin
            chk({28'h0, key_idx}, 32'(ntry));
            chk({24'h0, key_ofs}, 32'(ntry * 16));
            ntry++;
        end
    end
    // ==========================================================
    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        test_done();
    end
    // ==========================================================
    // test sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(12'h104, 32'h0);
        rd_chk(12'h108, 32'h0);
        rd_chk(12'h304, 32'h0);
        rd_chk(12'h308, 32'h0);
        rd_chk(12'h400, 32'h0);
        rd_chk(12'h500, 32'h0);
        rd_chk(12'h504, 32'h1);
        rd_chk(12'h0FC, 32'h0);
        $display("test reset values done");
        wr(12'h304, 32'h5);
        rd_chk(12'h304, 32'h5);
        rd_chk(12'h308, 32'h5);
        wr(12'h304, 32'h0);
        rd_chk(12'h304, 32'h5);
        wr(12'h308, 32'h4);
        rd_chk(12'h304, 32'h1);
        wr(12'h308, 32'h0);
        rd_chk(12'h308, 32'h1);
        wr(12'h304, 32'hFFFFFFFF);
        rd_chk(12'h304, 32'h7);
        wr(12'h400, 32'hFFFF);
        rd_chk(12'h400, 32'h0);
        wr(12'h500, 32'h3);
        rd_chk(12'h500, 32'h3);
        chk({31'h0, enabled}, 32'h1);
        $display("test enables done");
        scan(5'h04, 5'h02, 4'h5, 3);
        rd_chk(12'h104, 32'h1);
        rd_chk(12'h108, 32'h0);
        rd_chk(12'h100, 32'h1);
        rd_chk(12'h400, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(12'h104, 32'h0);
        wr(12'h100, 32'h0);
        rd_chk(12'h104, 32'h0);
        settle();
        chk({31'h0, irq}, 32'h0);
        $display("test slow match done");
        scan(5'h10, 5'h10, 4'h0, 16);
        rd_chk(12'h108, 32'h1);
        rd_chk(12'h104, 32'h0);
        rd_chk(12'h400, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(12'h308, 32'h5);
        settle();
        chk({31'h0, irq}, 32'h0);
        wr(12'h304, 32'h4);
        settle();
        chk({31'h0, irq}, 32'h1);
        wr(12'h108, 32'h0);
        wr(12'h100, 32'h0);
        settle();
        chk({31'h0, irq}, 32'h0);
        $display("test no match done");
        scan(5'h10, 5'h0F, 4'h1, 16);
        rd_chk(12'h400, 32'hF);
        rd_chk(12'h104, 32'h1);
        rd_chk(12'h108, 32'h0);
        $display("test last key done");
        rd_chk(12'h600, 32'h3);
        wr(12'h604, 32'h3);
        wr(12'h108, 32'h1);
        rd_chk(12'h600, 32'h4);
        scan(5'h00, 5'h10, 4'hF, 1);
        rd_chk(12'h600, 32'h5);
        wr(12'h604, 32'h7);
        wr(12'h504, 32'h10);
        rd_chk(12'h504, 32'h10);
        ntry = 0;
        wr(12'h000, 32'h1);
        settle();
        chk({31'h0, busy}, 32'h1);
        wr(12'h008, 32'h1);
        settle();
        chk({31'h0, busy}, 32'h0);
        chk(32'(ntry), 32'h1);
        rd_chk(12'h600, 32'h1);
        $display("test stop done");
        wr(12'h500, 32'h0);
        rd_chk(12'h500, 32'h0);
        chk({31'h0, enabled}, 32'h0);
        ntry = 0;
        wr(12'h000, 32'h1);
        repeat (6) @(posedge clk);
        chk(32'(ntry), 32'h0);
        $display("test disabled start done");
        test_done();
    end
endmodule
